// ### core/odpx_pkg.sv
// Constants, types and serial state encoding for the open-drain port expander
//==========================================================================
package odpx_pkg;
  //==========================================================================
  // Address map
  localparam logic [2:0] ADDR_FIXED = 3'h6;
  typedef enum logic [1:0] {
    CON_GND = 2'h0,
    CON_VP = 2'h1,
    CON_SCL = 2'h2,
    CON_SDA = 2'h3
  } odpx_con_e;
  localparam logic [1:0] HI_SCL = 2'h0;
  localparam logic [1:0] HI_SDA = 2'h1;
  localparam logic [1:0] HI_GND = 2'h2;
  localparam logic [1:0] HI_VP = 2'h3;
  localparam logic [1:0] LO_GND = 2'h0;
  localparam logic [1:0] LO_VP = 2'h1;
  localparam logic [1:0] LO_SCL = 2'h2;
  localparam logic [1:0] LO_SDA = 2'h3;
  //==========================================================================
  // Counts and reset values
  localparam int PORT_FILT = 4;
  localparam int BUS_FILT = 1;
  localparam logic [3:0] INIT_WAIT = 4'hC;
  localparam logic [4:0] WR_QUIET = 5'h14;
  localparam logic [3:0] BIT_LAST_RX = 4'h8;
  localparam logic [3:0] BIT_LAST_TX = 4'h7;
  localparam logic [7:0] OUT_RST = 8'hFF;
  localparam logic [7:0] PU_RST = 8'h00;
  //==========================================================================
  // Serial states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_BYTE = 3'h2,
    ST_WR_ACK = 3'h6,
    ST_RD_BYTE = 3'h7,
    ST_RD_ACK = 3'h5
  } odpx_state_e;
endpackage

// ### core/odpx_sync_filt.sv
// Three-stage pin synchroniser with stable-count filter
`timescale 1ns/1ns
module odpx_sync_filt #(
  parameter int FILT = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_ff, s2_ff, s3_ff, out_ff;
  logic [7:0] cnt_ff, nxt_cnt;
  logic nxt_out;

  //==========================================================================
  // Filter
  always_comb begin
    nxt_cnt = 8'h00;
    nxt_out = out_ff;
    if (s2_ff == s3_ff && s2_ff != out_ff) begin
      if (cnt_ff >= 8'(FILT - 1)) begin
        nxt_out = s2_ff;
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      out_ff <= 1'b1;
      cnt_ff <= 8'h00;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
      cnt_ff <= nxt_cnt;
    end
  end

  assign dout = out_ff;

  AST_FILT_AGREE: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(out_ff) |-> $past(s2_ff) == out_ff && $past(s3_ff) == out_ff)
    else $error("filtered level changed without stage agreement");
endmodule

// ### core/odpx_expander.sv
// Serial slave, address decode and transition detection of the port expander
`timescale 1ns/1ns
module odpx_expander #(
  parameter int PORT_FILT = odpx_pkg::PORT_FILT,
  parameter int BUS_FILT = odpx_pkg::BUS_FILT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic bus_abort_n_i,
  input wire logic low_group_addr_pin_i,
  input wire logic high_group_addr_pin_i,
  input wire logic [7:0] io_pins_i,
  output logic [7:0] io_pins_o,
  output logic [7:0] io_pins_oe,
  output logic [7:0] pullup_en,
  output logic alert_n,
  output logic [6:0] slave_addr
);
  //==========================================================================
  // Pin synchronisers
  logic [12:0] raw, syn;
  assign raw = {io_pins_i, high_group_addr_pin_i, low_group_addr_pin_i,
                bus_abort_n_i, sda_i, scl_i};
  for (genvar g = 0; g < 13; g++) begin : g_sync
    odpx_sync_filt #(.FILT(g >= 5 ? PORT_FILT : BUS_FILT)) u_sf (
      .clk_sys(clk_sys),
      .rst(rst),
      .din(raw[g]),
      .dout(syn[g])
    );
  end
  logic scl_s, sda_s, abort_n_s;
  logic [1:0] apin_s;
  logic [7:0] io_s;
  assign scl_s = syn[0];
  assign sda_s = syn[1];
  assign abort_n_s = syn[2];
  assign apin_s = syn[4:3];
  assign io_s = syn[12:5];

  //==========================================================================
  // Bus events
  logic scl_d_ff, sda_d_ff, drv_lo_ff;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  //==========================================================================
  // Address pin decode
  function automatic odpx_pkg::odpx_con_e con_of(input logic tog, input logic eqc,
                                                 input logic eqd, input logic lvl);
    if (tog && eqc) return odpx_pkg::CON_SCL;
    if (tog && eqd) return odpx_pkg::CON_SDA;
    return lvl ? odpx_pkg::CON_VP : odpx_pkg::CON_GND;
  endfunction

  function automatic logic [1:0] hi_bits(input odpx_pkg::odpx_con_e c);
    case (c)
      odpx_pkg::CON_SCL: return odpx_pkg::HI_SCL;
      odpx_pkg::CON_SDA: return odpx_pkg::HI_SDA;
      odpx_pkg::CON_GND: return odpx_pkg::HI_GND;
      default: return odpx_pkg::HI_VP;
    endcase
  endfunction

  function automatic logic [1:0] lo_bits(input odpx_pkg::odpx_con_e c);
    case (c)
      odpx_pkg::CON_GND: return odpx_pkg::LO_GND;
      odpx_pkg::CON_VP: return odpx_pkg::LO_VP;
      odpx_pkg::CON_SCL: return odpx_pkg::LO_SCL;
      default: return odpx_pkg::LO_SDA;
    endcase
  endfunction

  logic [1:0] eqc_ff, eqd_ff, tog_ff, lvl0_ff, nxt_eqc, nxt_eqd, nxt_tog, nxt_lvl0;
  odpx_pkg::odpx_con_e cur_hi, cur_lo;
  logic [6:0] cur_addr;
  assign cur_lo = con_of(tog_ff[0], eqc_ff[0], eqd_ff[0], apin_s[0]);
  assign cur_hi = con_of(tog_ff[1], eqc_ff[1], eqd_ff[1], apin_s[1]);
  assign cur_addr = {odpx_pkg::ADDR_FIXED, hi_bits(cur_hi), lo_bits(cur_lo)};

  //==========================================================================
  // Serial state machine and port configuration
  odpx_pkg::odpx_state_e state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt, init_ff, nxt_init;
  logic [7:0] sh_ff, nxt_sh, out_ff, nxt_out, pu_ff, nxt_pu;
  logic [6:0] addr_ff, nxt_addr;
  logic rw_ff, nxt_rw, mack_ff, nxt_mack, rdsel_ff, nxt_rdsel, full_ff, nxt_full;
  logic sda_oe_ff, nxt_sda_oe, snap_ev, wr_ev;
  logic [7:0] oe_ff, nxt_oe;
  logic [7:0] snap_ff, flags_ff, rdflags_ff, nxt_snap, nxt_flags, nxt_rdflags, diff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_rw = rw_ff;
    nxt_mack = mack_ff;
    nxt_rdsel = rdsel_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_out = out_ff;
    nxt_pu = pu_ff;
    nxt_addr = addr_ff;
    nxt_full = full_ff;
    nxt_init = init_ff;
    nxt_eqc = eqc_ff & ~(apin_s ^ {2{scl_s}});
    nxt_eqd = eqd_ff & ~(apin_s ^ {2{sda_s}});
    nxt_tog = tog_ff | (apin_s ^ lvl0_ff);
    nxt_lvl0 = lvl0_ff;
    snap_ev = 1'b0;
    wr_ev = 1'b0;
    if (!full_ff) begin
      nxt_addr = cur_addr;
      nxt_pu = {{4{apin_s[1]}}, {4{apin_s[0]}}};
    end
    if (init_ff != odpx_pkg::INIT_WAIT) begin
      nxt_init = init_ff + 4'h1;
      if (init_ff == odpx_pkg::INIT_WAIT - 4'h1) begin
        nxt_out = {{4{apin_s[1]}}, {4{apin_s[0]}}};
      end
    end
    if (!abort_n_s) begin
      nxt_state = odpx_pkg::ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (bus_start) begin
      nxt_state = odpx_pkg::ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_sda_oe = 1'b0;
      nxt_eqc = 2'b11;
      nxt_eqd = 2'b11;
      nxt_tog = 2'b00;
      nxt_lvl0 = apin_s;
    end else if (bus_stop) begin
      nxt_state = odpx_pkg::ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        odpx_pkg::ST_ADDR: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == odpx_pkg::BIT_LAST_RX) begin
            nxt_full = 1'b1;
            nxt_addr = cur_addr;
            nxt_pu = {{4{cur_hi != odpx_pkg::CON_GND}}, {4{cur_lo != odpx_pkg::CON_GND}}};
            if (sh_ff[7:1] == cur_addr) begin
              nxt_state = odpx_pkg::ST_ADDR_ACK;
              nxt_sda_oe = 1'b1;
              nxt_rw = sh_ff[0];
              nxt_rdsel = 1'b1;
              nxt_sh = io_s;
              snap_ev = 1'b1;
            end else begin
              nxt_state = odpx_pkg::ST_IDLE;
            end
          end
        end
        odpx_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_cnt = 4'h0;
            nxt_state = rw_ff ? odpx_pkg::ST_RD_BYTE : odpx_pkg::ST_WR_BYTE;
            nxt_sda_oe = rw_ff & ~sh_ff[7];
          end
        end
        odpx_pkg::ST_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt_ff == odpx_pkg::BIT_LAST_TX) begin
              nxt_state = odpx_pkg::ST_RD_ACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_cnt = cnt_ff + 4'h1;
              nxt_sda_oe = ~sh_ff[6];
            end
          end
        end
        odpx_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            nxt_mack = ~sda_s;
          end else if (scl_fall) begin
            nxt_cnt = 4'h0;
            if (!mack_ff) begin
              nxt_state = odpx_pkg::ST_IDLE;
            end else if (rdsel_ff) begin
              nxt_state = odpx_pkg::ST_RD_BYTE;
              nxt_sh = rdflags_ff;
              nxt_sda_oe = ~rdflags_ff[7];
              nxt_rdsel = 1'b0;
            end else begin
              nxt_state = odpx_pkg::ST_RD_BYTE;
              nxt_sh = io_s;
              nxt_sda_oe = ~io_s[7];
              nxt_rdsel = 1'b1;
              snap_ev = 1'b1;
            end
          end
        end
        odpx_pkg::ST_WR_BYTE: begin
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == odpx_pkg::BIT_LAST_RX) begin
            nxt_state = odpx_pkg::ST_WR_ACK;
            nxt_sda_oe = 1'b1;
            nxt_out = sh_ff;
            wr_ev = 1'b1;
          end
        end
        odpx_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            nxt_state = odpx_pkg::ST_WR_BYTE;
            nxt_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
          end
        end
        default: nxt_state = odpx_pkg::ST_IDLE;
      endcase
    end
    nxt_oe = ~nxt_out;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= odpx_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
      rdsel_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      out_ff <= odpx_pkg::OUT_RST;
      oe_ff <= ~odpx_pkg::OUT_RST;
      pu_ff <= odpx_pkg::PU_RST;
      addr_ff <= 7'h00;
      full_ff <= 1'b0;
      init_ff <= 4'h0;
      eqc_ff <= 2'b00;
      eqd_ff <= 2'b00;
      tog_ff <= 2'b00;
      lvl0_ff <= 2'b00;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      drv_lo_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      rw_ff <= nxt_rw;
      mack_ff <= nxt_mack;
      rdsel_ff <= nxt_rdsel;
      sda_oe_ff <= nxt_sda_oe;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      pu_ff <= nxt_pu;
      addr_ff <= nxt_addr;
      full_ff <= nxt_full;
      init_ff <= nxt_init;
      eqc_ff <= nxt_eqc;
      eqd_ff <= nxt_eqd;
      tog_ff <= nxt_tog;
      lvl0_ff <= nxt_lvl0;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      drv_lo_ff <= 1'b0;
    end
  end

  //==========================================================================
  // Transition detection
  logic [4:0] quiet_ff, nxt_quiet;
  logic alert_n_ff, nxt_alert_n, rd_active;
  assign rd_active = state_ff == odpx_pkg::ST_RD_BYTE || state_ff == odpx_pkg::ST_RD_ACK ||
                     (state_ff == odpx_pkg::ST_ADDR_ACK && rw_ff);
  assign diff = (quiet_ff == 5'h00) ? (io_s ^ snap_ff) : 8'h00;

  always_comb begin
    nxt_snap = snap_ff;
    nxt_flags = flags_ff | diff;
    nxt_rdflags = rdflags_ff;
    nxt_quiet = (quiet_ff != 5'h00) ? quiet_ff - 5'h01 : 5'h00;
    nxt_alert_n = alert_n_ff;
    if (wr_ev || init_ff != odpx_pkg::INIT_WAIT) begin
      nxt_quiet = odpx_pkg::WR_QUIET;
    end
    if (quiet_ff != 5'h00) begin
      nxt_snap = io_s;
    end
    if (snap_ev) begin
      nxt_snap = io_s;
      nxt_rdflags = flags_ff | diff;
      nxt_flags = 8'h00;
      nxt_alert_n = 1'b1;
    end else if (diff != 8'h00 && !rd_active) begin
      nxt_alert_n = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      snap_ff <= 8'hFF;
      flags_ff <= 8'h00;
      rdflags_ff <= 8'h00;
      quiet_ff <= odpx_pkg::WR_QUIET;
      alert_n_ff <= 1'b1;
    end else begin
      snap_ff <= nxt_snap;
      flags_ff <= nxt_flags;
      rdflags_ff <= nxt_rdflags;
      quiet_ff <= nxt_quiet;
      alert_n_ff <= nxt_alert_n;
    end
  end

  //==========================================================================
  // Outputs
  assign sda_o = drv_lo_ff;
  assign sda_oe = sda_oe_ff;
  assign io_pins_o = {8{drv_lo_ff}};
  assign io_pins_oe = oe_ff;
  assign pullup_en = pu_ff;
  assign alert_n = alert_n_ff;
  assign slave_addr = addr_ff;

  //==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_ABORT_IDLE: assert property (!abort_n_s |=> state_ff == odpx_pkg::ST_IDLE
    && !sda_oe_ff) else $error("abort did not return serial logic to idle");
  AST_ABORT_ALERT: assert property (!abort_n_s && !snap_ev && (diff == 8'h00 || !alert_n_ff)
    |=> $stable(alert_n_ff)) else $error("abort changed the alert");
  AST_ADDR_FIX: assert property (addr_ff[6:4] == odpx_pkg::ADDR_FIXED || !full_ff)
    else $error("fixed address bits wrong");
  AST_ACK_CLEAR: assert property (snap_ev |=> flags_ff == 8'h00 && alert_n_ff
    && snap_ff == $past(io_s)) else $error("acknowledge did not snapshot and clear");
  AST_FLAG_STICKY: assert property ((flags_ff != 8'h00) && !snap_ev
    |=> (flags_ff & $past(flags_ff)) == $past(flags_ff)) else $error("flag lost");
  AST_DIFF_ALERT: assert property (diff != 8'h00 && !rd_active && !snap_ev
    |=> !alert_n_ff ##0 flags_ff != 8'h00) else $error("change not reported");
  AST_WRITE_PORTS: assert property (wr_ev |=> io_pins_oe == ~$past(sh_ff)
    ##1 quiet_ff != 5'h00) else $error("write did not set all ports");
  AST_PULLUP_MAP: assert property (full_ff && $rose(full_ff) |-> pu_ff ==
    {{4{hi_bits(odpx_pkg::CON_GND) != addr_ff[3:2]}},
     {4{lo_bits(odpx_pkg::CON_GND) != addr_ff[1:0]}}}) else $error("pullups wrong");
  AST_READ_FIRST: assert property (snap_ev && state_ff == odpx_pkg::ST_ADDR
    |=> sh_ff == $past(io_s)) else $error("read byte is not the pin level");

  COV_WRITE: cover property (wr_ev);
  COV_READ2: cover property (state_ff == odpx_pkg::ST_RD_BYTE && !rdsel_ff);
  COV_ABORT: cover property (!abort_n_s && state_ff != odpx_pkg::ST_IDLE);
  COV_ALERT: cover property ($fell(alert_n_ff));
endmodule

// ### test/odpx_i2c_master.sv
// Bus master model that drives the expander's serial clock and data lines
`timescale 1ns/1ns
module odpx_i2c_master (
  input wire logic clk_sys,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  //==========================================================================
  // Idle bus: both lines released, clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  //==========================================================================
  // Bus cycles, clock high and low eight cycles each
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic start();
    sda_o = 1'b1;
    wait_clk(4);
    scl_o = 1'b1;
    wait_clk(8);
    sda_o = 1'b0;
    wait_clk(8);
    scl_o = 1'b0;
    wait_clk(4);
  endtask
  task automatic stop();
    sda_o = 1'b0;
    wait_clk(4);
    scl_o = 1'b1;
    wait_clk(8);
    sda_o = 1'b1;
    wait_clk(8);
  endtask
  task automatic bit_xfer(input logic b, output logic r);
    sda_o = b;
    wait_clk(4);
    scl_o = 1'b1;
    wait_clk(4);
    r = sda_i;
    wait_clk(4);
    scl_o = 1'b0;
    wait_clk(4);
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, ack);
  endtask
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(last, r);
  endtask
endmodule

// ### test/tb.sv
// Self-checking testbench of the open-drain port expander
`timescale 1ns/1ns
module tb;
  //==========================================================================
  // Clock, reset and wiring
  function automatic logic pin_of(input odpx_pkg::odpx_con_e s, input logic c, input logic d);
    case (s)
      odpx_pkg::CON_GND: return 1'b0;
      odpx_pkg::CON_VP: return 1'b1;
      odpx_pkg::CON_SCL: return c;
      default: return d;
    endcase
  endfunction
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic bus_abort_n = 1'b1;
  logic [7:0] ext_io = 8'hFF;
  odpx_pkg::odpx_con_e hi_sel = odpx_pkg::CON_GND;
  odpx_pkg::odpx_con_e lo_sel = odpx_pkg::CON_VP;
  logic scl, sda_m, sda_o, sda_oe, alert_n;
  logic [7:0] io_o, io_oe, pullup_en;
  logic [6:0] slave_addr;
  wire sda_w = sda_m & ~(sda_oe & ~sda_o);
  wire [7:0] io_w = (io_oe & io_o) | (~io_oe & ext_io);
  wire lo_pin = pin_of(lo_sel, scl, sda_w);
  wire hi_pin = pin_of(hi_sel, scl, sda_w);
  int num_errors = 0;
  int cmp_count = 0;
  always #2 clk_sys = ~clk_sys;
  odpx_expander dut (
    .clk_sys(clk_sys), .rst(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .bus_abort_n_i(bus_abort_n), .low_group_addr_pin_i(lo_pin),
    .high_group_addr_pin_i(hi_pin), .io_pins_i(io_w), .io_pins_o(io_o),
    .io_pins_oe(io_oe), .pullup_en(pullup_en), .alert_n(alert_n), .slave_addr(slave_addr)
  );
  odpx_i2c_master mst (.clk_sys(clk_sys), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  //==========================================================================
  // Shared tasks
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("Counts: %0d mismatches in %0d comparisons", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_alert();
    int n;
    n = 0;
    while (alert_n !== 1'b0 && n < 40) begin
      wait_clk(1);
      n++;
    end
    if (alert_n !== 1'b0) begin
      num_errors++;
      $display("BAD t=%0t alert wait got=%h exp=%h", $time, alert_n, 1'b0);
      final_report();
    end
  endtask
  task automatic addr_frame(input logic [6:0] a, input logic rw, output logic ack);
    mst.start();
    mst.write_byte({a, rw}, ack);
  endtask
  //==========================================================================
  // Scenarios
  task automatic test_reset();
    wait_clk(30);
    chk_bit(alert_n, 1'b1);
    chk_byte(io_oe, 8'hF0);
    chk_byte(pullup_en, 8'h0F);
    chk_byte({1'b0, slave_addr}, 8'h69);
    $display("test_reset done");
  endtask
  task automatic test_write();
    logic ack;
    addr_frame(7'h69, 1'b0, ack);
    chk_bit(ack, 1'b0);
    mst.write_byte(8'hA5, ack);
    chk_byte(io_oe, 8'h5A);
    mst.write_byte(8'h3C, ack);
    chk_byte(io_oe, 8'hC3);
    chk_byte(io_o, 8'h00);
    mst.stop();
    wait_clk(40);
    chk_bit(alert_n, 1'b1);
    addr_frame(7'h68, 1'b0, ack);
    mst.stop();
    chk_bit(ack, 1'b1);
    chk_byte(io_oe, 8'hC3);
    $display("test_write done");
  endtask
  task automatic test_read();
    logic ack;
    logic [7:0] d;
    addr_frame(7'h69, 1'b0, ack);
    mst.write_byte(8'hFF, ack);
    mst.stop();
    wait_clk(40);
    chk_byte(io_oe, 8'h00);
    ext_io = 8'hF7;
    wait_alert();
    chk_bit(alert_n, 1'b0);
    for (int k = 0; k < 2; k++) begin
      addr_frame(7'h69, 1'b1, ack);
      chk_bit(alert_n, 1'b1);
      mst.read_byte(1'b0, d);
      chk_byte(d, 8'hF7);
      mst.read_byte(1'b1, d);
      chk_byte(d, (k == 0) ? 8'h08 : 8'h00);
      mst.stop();
      wait_clk(20);
    end
    chk_bit(alert_n, 1'b1);
    $display("test_read done");
  endtask
  task automatic test_abort();
    logic r;
    logic [7:0] d;
    ext_io = 8'hFF;
    wait_alert();
    mst.start();
    for (int i = 7; i >= 4; i--) begin
      mst.bit_xfer(d_addr(i), r);
    end
    bus_abort_n = 1'b0;
    wait_clk(10);
    bus_abort_n = 1'b1;
    wait_clk(10);
    chk_bit(sda_oe, 1'b0);
    chk_bit(alert_n, 1'b0);
    for (int i = 3; i >= 0; i--) begin
      mst.bit_xfer(d_addr(i), r);
    end
    mst.bit_xfer(1'b1, r);
    mst.stop();
    chk_bit(r, 1'b1);
    chk_bit(alert_n, 1'b0);
    chk_byte(io_oe, 8'h00);
    addr_frame(7'h69, 1'b1, r);
    chk_bit(r, 1'b0);
    mst.read_byte(1'b1, d);
    mst.stop();
    chk_byte(d, 8'hFF);
    $display("test_abort done");
  endtask
  function automatic logic d_addr(input int i);
    logic [7:0] a;
    a = {7'h69, 1'b0};
    return a[i];
  endfunction
  task automatic test_addr();
    odpx_pkg::odpx_con_e hs [4] = '{odpx_pkg::CON_SCL, odpx_pkg::CON_SDA,
                                   odpx_pkg::CON_GND, odpx_pkg::CON_VP};
    odpx_pkg::odpx_con_e ls [4] = '{odpx_pkg::CON_GND, odpx_pkg::CON_VP,
                                   odpx_pkg::CON_SCL, odpx_pkg::CON_SDA};
    logic [7:0] ea [4] = '{8'h60, 8'h65, 8'h6A, 8'h6F};
    logic [7:0] ep [4] = '{8'hF0, 8'hFF, 8'h0F, 8'hFF};
    logic ack;
    for (int k = 0; k < 4; k++) begin
      hi_sel = hs[k];
      lo_sel = ls[k];
      wait_clk(4);
      addr_frame(7'h10, 1'b0, ack);
      mst.stop();
      wait_clk(8);
      chk_byte({1'b0, slave_addr}, ea[k]);
      chk_byte(pullup_en, ep[k]);
    end
    addr_frame(7'h6F, 1'b0, ack);
    chk_bit(ack, 1'b0);
    mst.write_byte(8'h0F, ack);
    mst.stop();
    chk_byte(io_oe, 8'hF0);
    $display("test_addr done");
  endtask
  task automatic test_filter();
    logic ack;
    logic [7:0] d;
    ext_io = 8'hFD;
    wait_clk(3);
    ext_io = 8'hFF;
    wait_clk(20);
    chk_bit(alert_n, 1'b1);
    ext_io = 8'hFE;
    wait_clk(20);
    chk_bit(alert_n, 1'b0);
    addr_frame(7'h6F, 1'b1, ack);
    chk_bit(ack, 1'b0);
    mst.read_byte(1'b0, d);
    chk_byte(d, 8'h0E);
    mst.read_byte(1'b0, d);
    chk_byte(d, 8'h01);
    mst.read_byte(1'b1, d);
    chk_byte(d, 8'h0E);
    mst.stop();
    $display("test_filter done");
  endtask
  //==========================================================================
  // Main sequence and watchdog
  initial begin
    wait_clk(3);
    rst = 1'b0;
    test_reset();
    test_write();
    test_read();
    test_abort();
    test_addr();
    test_filter();
    final_report();
  end
  initial begin
    wait_clk(100000);
    num_errors++;
    final_report();
  end
endmodule
